//--- rtl/tmr_top.v
// Sixteen-bit prescaled timer with its Avalon-MM register slave and interrupt.
`timescale 1ns/1ns
`include "tmr_defines.vh"
module tmr_top #(
	parameter PS_WIDTH = 8
) (
	input wire clk,
	input wire rst,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire external_count_pin,
	input wire vector_ack,
	output wire irq
);

	// Register select codes returned by the decoder.
	localparam SEL_NONE = 3'h0;
	localparam SEL_CTRL = 3'h1;
	localparam SEL_LO = 3'h2;
	localparam SEL_HI = 3'h3;
	localparam SEL_STAT = 3'h4;
	localparam SEL_MASK = 3'h5;

	// Bus handshake states, one-hot.
	localparam ST_IDLE = 2'b01;
	localparam ST_ACK = 2'b10;

	reg [1:0] bus_q;
	reg [1:0] bus_d;
	reg [7:0] ctrl_q;
	reg [15:0] cnt_q;
	reg [15:0] cnt_d;
	reg ovf_q;
	reg ovf_d;
	reg ovf_en_q;
	reg [1:0] phase_q;
	reg pin_q;
	reg [31:0] rdata_d;
	reg wrap;

	wire [2:0] sel;
	wire req;
	wire wr_go;
	wire wr_be0;
	wire wr_lo;
	wire wr_hi;
	wire src_int;
	wire edge_rise;
	wire [3:0] ps_sel;
	wire ext_edge;
	wire ext_level;
	wire int_tick;
	wire sample_en;
	wire prescaler_output;
	wire int_inc;
	wire ext_inc;
	wire inc;

	// Maps a byte address to a register select; used by read and write paths.
	function [2:0] decode;
		input [4:0] addr;
		begin
			case (addr & 5'h1c)
				`TMR_OFS_CTRL: begin
					decode = SEL_CTRL;
				end
				`TMR_OFS_CNT_LO: begin
					decode = SEL_LO;
				end
				`TMR_OFS_CNT_HI: begin
					decode = SEL_HI;
				end
				`TMR_OFS_IRQ_STATUS: begin
					decode = SEL_STAT;
				end
				`TMR_OFS_IRQ_MASK: begin
					decode = SEL_MASK;
				end
				default: begin
					decode = SEL_NONE;
				end
			endcase
		end
	endfunction

	// Control fields.
	assign src_int = ctrl_q[`TMR_CTRL_SRC_BIT];
	assign edge_rise = ctrl_q[`TMR_CTRL_EDGE_BIT];
	assign ps_sel = ctrl_q[`TMR_CTRL_PS_HI:`TMR_CTRL_PS_LO];

	// Bus request decode; a write acts only at the edge where waitrequest is low.
	assign sel = decode(avs_address);
	assign req = avs_read | avs_write;
	assign wr_go = avs_write & bus_q[1];
	assign wr_be0 = wr_go & avs_byteenable[0];
	assign wr_lo = wr_be0 & (sel == SEL_LO);
	assign wr_hi = wr_be0 & (sel == SEL_HI);

	// Every access takes exactly one wait cycle, which gives read data a register stage.
	assign avs_waitrequest = ~bus_q[1];

	always @* begin
		case (bus_q)
			ST_IDLE: begin
				bus_d = req ? ST_ACK : ST_IDLE;
			end
			ST_ACK: begin
				bus_d = ST_IDLE;
			end
			default: begin
				bus_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			bus_q <= ST_IDLE;
		end else begin
			bus_q <= bus_d;
		end
	end

	// Read data mux; unmapped addresses read as zero.
	always @* begin
		rdata_d = 32'h00000000;
		case (sel)
			SEL_CTRL: begin
				rdata_d[7:0] = ctrl_q & `TMR_CTRL_WMASK;
			end
			SEL_LO: begin
				rdata_d[7:0] = cnt_q[7:0];
			end
			SEL_HI: begin
				rdata_d[7:0] = cnt_q[15:8];
			end
			SEL_STAT: begin
				rdata_d[`TMR_IRQ_OVF_BIT] = ovf_q;
			end
			SEL_MASK: begin
				rdata_d[`TMR_IRQ_OVF_BIT] = ovf_en_q;
			end
			default: begin
				rdata_d = 32'h00000000;
			end
		endcase
	end

	// Read data is loaded at the edge that ends the wait cycle.
	always @(posedge clk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & bus_q[0]) begin
			avs_readdata <= rdata_d;
		end
	end

	// Control and mask registers; bit 0 of control is not implemented.
	always @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `TMR_CTRL_RESET;
			ovf_en_q <= `TMR_MASK_RESET;
		end else begin
			if (wr_be0 & (sel == SEL_CTRL)) begin
				ctrl_q <= avs_writedata[7:0] & `TMR_CTRL_WMASK;
			end
			if (wr_be0 & (sel == SEL_MASK)) begin
				ovf_en_q <= avs_writedata[`TMR_IRQ_OVF_BIT];
			end
		end
	end

	// Instruction-cycle phase counter: four oscillator periods per cycle.
	always @(posedge clk) begin
		if (rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1; // [RULE14]
		end
	end

	// One tick per instruction cycle, and two sample points per cycle.
	assign int_tick = (phase_q == `TMR_PHASE_LAST); // [RULE14]
	assign sample_en = phase_q[0]; // [RULE11]

	// Pin edge detect; the pin is already synchronous to clk.
	always @(posedge clk) begin
		if (rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= external_count_pin;
		end
	end

	// Rising or falling transition per the edge select bit.
	assign ext_edge = edge_rise ? (external_count_pin & ~pin_q) // [RULE3]
		: (~external_count_pin & pin_q); // [RULE4]
	assign ext_level = edge_rise ? external_count_pin : ~external_count_pin;

	// A write to either counter byte clears the prescaler, so an internal count starts from a whole period and a prescaled external one from half.
	tmr_prescaler #(
		.W(PS_WIDTH)
	) u_prescaler (
		.clk(clk),
		.rst(rst),
		.clear(wr_lo | wr_hi), // [RULE13]
		.src_ext(~src_int),
		.ext_level(ext_level),
		.ext_edge(ext_edge),
		.int_tick(int_tick),
		.ps_sel(ps_sel),
		.prescaler_output_q(prescaler_output),
		.int_inc_q(int_inc)
	);

	// The external path is phase-sampled after the prescaler, not at the pin.
	tmr_prescaler_output_sampler u_sampler (
		.clk(clk),
		.rst(rst),
		.sample_en(sample_en),
		.prescaler_output(prescaler_output),
		.rise_q(ext_inc)
	);

	// Increment source; pin path lands three or four periods after the edge.
	assign inc = src_int ? int_inc : ext_inc; // [RULE1] [RULE2] [RULE12]

	// Counter next value. A byte write holds that half still for the cycle,
	// while the other half keeps counting, so software writes low then high.
	always @* begin
		cnt_d = cnt_q;
		wrap = 1'b0;
		if (wr_lo) begin
			cnt_d[7:0] = avs_writedata[7:0];
			if (inc & (cnt_q[7:0] == 8'hff)) begin
				cnt_d[15:8] = cnt_q[15:8] + 8'h01;
			end
		end else if (wr_hi) begin
			cnt_d[15:8] = avs_writedata[7:0];
			if (inc) begin
				cnt_d[7:0] = cnt_q[7:0] + 8'h01;
			end
		end else if (inc) begin
			cnt_d = cnt_q + 16'h0001; // [RULE6]
			wrap = (cnt_q == 16'hffff); // [RULE7]
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= `TMR_CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Overflow flag: a wrap in the same cycle as a clear wins over the clear.
	always @* begin
		ovf_d = ovf_q;
		if (vector_ack) begin
			ovf_d = 1'b0; // [RULE9]
		end
		if (wr_go & avs_byteenable[0] & (sel == SEL_STAT) & avs_writedata[`TMR_IRQ_OVF_BIT]) begin
			ovf_d = 1'b0;
		end
		if (wrap) begin
			ovf_d = 1'b1; // [RULE7]
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= ovf_d;
		end
	end

	// The flag stays visible in status even while the request is masked.
	assign irq = ovf_q & ovf_en_q; // [RULE8]

endmodule

//--- rtl/tmr_defines.vh
// Constants shared by the prescaled sixteen-bit timer design files.
// Functional notes
// [RULE1] With the source select bit set the counter advances on the prescaled instruction clock.
// [RULE2] With the source select bit clear the counter advances on the external count pin.
// [RULE3] In external mode with the edge select bit set, rising pin transitions are counted.
// [RULE4] In external mode with the edge select bit clear, falling pin transitions are counted.
// [RULE5] The four-bit prescale code picks 1:1 up to 1:256 in powers of two, any code 1xxx is 1:256.
// [RULE6] The counter counts up through its whole range and wraps from all-ones to zero.
// [RULE7] Every wrap from all-ones to zero sets the overflow flag.
// [RULE8] The interrupt request is held off while the overflow enable bit is clear.
// [RULE9] The overflow flag clears by itself when the processor vectors to the timer handler.
// [RULE10] An external count is brought onto the internal phase clocks after the prescaler.
// [RULE11] The prescaler output is sampled twice per instruction cycle to find its edges.
// [RULE12] The counter changes between three and seven oscillator periods after an external edge.
// [RULE13] Any software write to either counter byte clears the prescaler.
// [RULE14] The internal source is the instruction clock at a quarter of the oscillator rate.
// [RULE15] The prescaler is an eight-bit counter whose selected power-of-two tap is its output.
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// Register byte offsets on the Avalon-MM slave.
`define TMR_OFS_CTRL 5'h00
`define TMR_OFS_CNT_LO 5'h04
`define TMR_OFS_CNT_HI 5'h08
`define TMR_OFS_IRQ_STATUS 5'h0c
`define TMR_OFS_IRQ_MASK 5'h10

// Field positions in the control and status register.
`define TMR_CTRL_EDGE_BIT 6
`define TMR_CTRL_SRC_BIT 5
`define TMR_CTRL_PS_HI 4
`define TMR_CTRL_PS_LO 1
`define TMR_CTRL_WMASK 8'h7e
`define TMR_IRQ_OVF_BIT 0

// Reset values.
`define TMR_CTRL_RESET 8'h00
`define TMR_CNT_RESET 16'h0000
`define TMR_MASK_RESET 1'b0

// Timing: oscillator periods per instruction cycle and the external edge window.
`define TMR_OSC_PER_CYCLE 4
`define TMR_PHASE_LAST 2'h3
`define TMR_EXT_DELAY_MIN_TOSC 3
`define TMR_EXT_DELAY_MAX_TOSC 7

`endif

//--- rtl/tmr_prescaler.v
// Eight-bit power-of-two prescaler shared by the internal and external count sources.
`timescale 1ns/1ns
module tmr_prescaler #(
	parameter W = 8
) (
	input wire clk,
	input wire rst,
	input wire clear,
	input wire src_ext,
	input wire ext_level,
	input wire ext_edge,
	input wire int_tick,
	input wire [3:0] ps_sel,
	output reg prescaler_output_q,
	output reg int_inc_q
);

	reg [W-1:0] cnt_q;
	reg [W-1:0] cnt_d;
	reg [W-1:0] tap;
	reg [W-1:0] mask;
	wire event_in;

	// One-hot tap of the selected ratio; zero stands for 1:1.
	function [W-1:0] tap_of;
		input [3:0] sel;
		begin
			if (sel[3]) begin
				tap_of = {1'b1, {(W-1){1'b0}}}; // [RULE5]
			end else if (sel[2:0] == 3'h0) begin
				tap_of = {W{1'b0}};
			end else begin
				tap_of = {{(W-1){1'b0}}, 1'b1} << (sel[2:0] - 3'h1); // [RULE5]
			end
		end
	endfunction

	assign event_in = src_ext ? ext_edge : int_tick; // [RULE14]

	// Next count and the tap decode.
	always @* begin
		tap = tap_of(ps_sel);
		mask = tap | (tap - {{(W-1){1'b0}}, 1'b1});
		if (tap == {W{1'b0}}) begin
			mask = {W{1'b0}};
		end
		if (clear) begin
			cnt_d = {W{1'b0}}; // [RULE13]
		end else if (event_in) begin
			cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1}; // [RULE15]
		end else begin
			cnt_d = cnt_q;
		end
	end

	// At 1:1 the output follows the edge-adjusted pin, otherwise the tap bit.
	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= {W{1'b0}};
			prescaler_output_q <= 1'b0;
			int_inc_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			prescaler_output_q <= (tap == {W{1'b0}}) ? ext_level : |(cnt_d & tap); // [RULE15]
			int_inc_q <= ~clear & ~src_ext & int_tick & ((cnt_q & mask) == mask); // [RULE1]
		end
	end

endmodule

//--- rtl/tmr_prescaler_output_sampler.v
// Samples the prescaler output on two phases of each instruction cycle.
`timescale 1ns/1ns
module tmr_prescaler_output_sampler (
	input wire clk,
	input wire rst,
	input wire sample_en,
	input wire prescaler_output,
	output reg rise_q
);

	reg samp_q;

	// The edge is judged only between two phase samples, never on the raw level.
	// The sample starts high so that a prescaler output already high at reset
	// (falling-edge mode with the pin idle low) is not taken for a count.
	always @(posedge clk) begin
		if (rst) begin
			samp_q <= 1'b1;
			rise_q <= 1'b0;
		end else begin
			rise_q <= sample_en & prescaler_output & ~samp_q; // [RULE11]
			if (sample_en) begin
				samp_q <= prescaler_output; // [RULE10]
			end
		end
	end

endmodule

//--- verif/tmr_sva.sv
// Checker for the timer's register bus and interrupt output.
`timescale 1ns/1ns
module tmr_sva (
	input wire clk,
	input wire rst,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire vector_ack,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// A request seen in the idle cycle.
	sequence s_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	chk_one_wait: assert property (s_take |-> ##1 !avs_waitrequest) else $error("no ack");
	chk_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("ack when idle");
	chk_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
	chk_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest && !irq
		&& avs_readdata == 32'h0) else $error("reset state");
	chk_rdata_hold: assert property (!$stable(avs_readdata) |->
		$past(avs_read && avs_waitrequest)) else $error("readdata moved");
	chk_ctrl_pad: assert property (avs_read && avs_waitrequest && avs_address[4:2] == 3'h0
		|=> avs_readdata[31:8] == 24'h0 && !avs_readdata[7] && !avs_readdata[0])
		else $error("control pad bits");
	chk_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address[4:2] > 3'h4
		|=> avs_readdata == 32'h0) else $error("unmapped read");
	chk_irq_fall: assert property ($fell(irq) |->
		$past(vector_ack || avs_write && !avs_waitrequest)) else $error("irq dropped");
endmodule

//--- verif/tmr_ext_src.sv
// Model of the external source that drives the timer's count pin.
`timescale 1ns/1ns
module tmr_ext_src (
	input wire clk,
	output logic pin
);
	// Push-pull source: the pin idles low between bursts and always carries a level.
	initial pin = 1'b0;
	// Emits n full pulses; each level stands hold cycles, so slow and prompt sources both occur.
	task automatic burst(input int n, input int hold);
		repeat (2 * n) begin
			repeat (hold) @(posedge clk);
			pin <= ~pin;
		end
	endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the prescaled timer.
`timescale 1ns/1ns
module testbench;
	localparam logic [32:0] ck = 33'h100000000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_pin;
	logic vector_ack = 1'b0;
	logic irq;
	logic [32:0] exq[$];
	logic [31:0] d;
	int n_fail = 0;
	int comparisons = 0;
	// Four nanosecond oscillator period.
	always #2 clk = ~clk;
	tmr_top u_tmr_top (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.external_count_pin(ext_pin), .vector_ack(vector_ack), .irq(irq));
	tmr_ext_src u_tmr_ext_src (.clk(clk), .pin(ext_pin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One transfer; the request stands until waitrequest is seen low at a rising edge.
	task automatic bus(input logic [4:0] a, input logic r, input logic [7:0] v,
		input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_read <= r;
		avs_write <= !r;
		avs_writedata <= {24'h0, v};
		avs_byteenable <= be;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		bus(a, 1'b0, v, 4'hf);
	endtask
	// The top bit of a note says whether the read value is compared.
	task automatic rd(input logic [4:0] a, input logic [32:0] e);
		exq.push_back(e);
		bus(a, 1'b1, 8'h00, 4'hf);
	endtask
	task automatic chk_irq(input logic e, input string what);
		@(negedge clk);
		check({31'h0, irq}, {31'h0, e}, what);
	endtask
	// Each read result is paired with the oldest note, and compared when its top bit is set.
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0 && exq.size() > 0) begin
			if (exq[0][32]) check(avs_readdata, exq[0][31:0], "readdata");
			void'(exq.pop_front());
		end
	end
	// Cuts a hung run short; well beyond the expected length.
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		wrap_up;
	end
	initial begin
		logic [7:0] r;
		logic [7:0] base;
		int n;
		void'($urandom(32'hd25b5f98));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values, an unmapped place and a refused byte lane.
		for (int a = 0; a < 6; a++) rd(5'(a * 4), ck);
		wr(5'h14, 8'hff);
		rd(5'h14, ck);
		r = 8'($urandom);
		wr(5'h00, r);
		bus(5'h00, 1'b0, ~r, 4'he);
		rd(5'h00, ck | {25'h0, r & 8'h7e});
		$display("test registers done");
		// Any span of 12 * n oscillator periods, three prescaled periods, holds exactly three steps, whatever the phase.
		for (int k = 0; k < 10; k++) begin
			n = (k > 7) ? 256 : (1 << k);
			wr(5'h00, 8'h20 | 8'(((k == 9) ? 12 : k) << 1));
			wr(5'h04, 8'h00);
			rd(5'h04, 33'h0);
			base = d[7:0];
			repeat (12 * n - 3) @(posedge clk);
			rd(5'h04, ck | {25'h0, base + 8'h03});
		end
		$display("test internal prescale done");
		// Preload near the top, then mask, vectoring and write-one-to-clear.
		wr(5'h00, 8'h20);
		wr(5'h10, 8'h01);
		for (int p = 0; p < 2; p++) begin
			wr(5'h04, 8'hf0);
			wr(5'h08, 8'hff);
			repeat (200) @(posedge clk);
			rd(5'h08, ck);
			rd(5'h0c, ck | 33'h1);
			chk_irq(1'b1, "irq set");
			if (p == 0) begin
				wr(5'h10, 8'h00);
				chk_irq(1'b0, "irq masked");
				wr(5'h10, 8'h01);
				chk_irq(1'b1, "irq unmasked");
				@(posedge clk);
				vector_ack <= 1'b1;
				@(posedge clk);
				vector_ack <= 1'b0;
			end else begin
				wr(5'h0c, 8'h01);
			end
			chk_irq(1'b0, "irq cleared");
			rd(5'h0c, ck);
		end
		$display("test overflow done");
		// Rising, falling and one-in-four external counting with random hold times.
		for (int k = 0; k < 3; k++) begin
			wr(5'h00, (k == 1) ? 8'h00 : ((k == 2) ? 8'h44 : 8'h40));
			repeat (10) @(posedge clk);
			wr(5'h04, 8'h00);
			wr(5'h08, 8'h00);
			u_tmr_ext_src.burst(8, $urandom_range(6, 3));
			repeat (10) @(posedge clk);
			rd(5'h04, ck | ((k == 2) ? 33'h2 : 33'h8));
		end
		// One rising edge at 1:1: the count is still old three periods after the edge
		// and has stepped by eight periods after it, so the update falls in the window.
		wr(5'h00, 8'h40);
		wr(5'h04, 8'h00);
		wr(5'h08, 8'h00);
		fork
			u_tmr_ext_src.burst(1, 4);
			begin
				repeat (5) @(posedge clk);
				rd(5'h04, ck);
				repeat (2) @(posedge clk);
				rd(5'h04, ck | 33'h1);
			end
		join
		// A counter write empties a part-filled prescaler at 1:256.
		wr(5'h00, 8'h30);
		wr(5'h04, 8'h00);
		repeat (800) @(posedge clk);
		wr(5'h04, 8'h05);
		repeat (800) @(posedge clk);
		rd(5'h04, ck | 33'h5);
		$display("test external and clear done");
		wrap_up;
	end
endmodule
bind tmr_top tmr_sva u_tmr_sva (.clk(clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .vector_ack(vector_ack), .irq(irq));
